/* hw/mstt_pkg.sv */
package mstt_pkg;

   // ************************************************************
   // frame geometry
   // ************************************************************
   localparam int unsigned ROW_W = 4;
   localparam int unsigned COL_W = 9;
   localparam int unsigned LANE_W = 2;
   localparam logic [3:0] ROW_LAST = 4'h8;
   localparam logic [8:0] COL_LAST = 9'h10d;
   localparam logic [1:0] LANE_LAST = 2'h2;
   localparam logic [3:0] RSOH_ROWS = 4'h3;
   localparam logic [8:0] RSOH_COLS = 9'h009;

   // ************************************************************
   // overhead byte positions, zero based
   // ************************************************************
   localparam logic [3:0] B2_ROW = 4'h4;
   localparam logic [8:0] B2_COLS = 9'h003;
   localparam logic [8:0] K1_COL = 9'h003;
   localparam logic [8:0] K2_COL = 9'h006;
   localparam logic [3:0] M1_ROW = 4'h8;
   localparam logic [8:0] M1_COL = 9'h005;

   // ************************************************************
   // codes and timing
   // ************************************************************
   localparam logic [4:0] REI_MAX = 5'h18;
   localparam logic [6:0] REI_CODE_MAX = 7'h18;
   localparam logic [2:0] RDI_ON = 3'h6;
   localparam logic [2:0] RDI_OFF = 3'h0;
   localparam logic [2:0] APS_PAD = 3'h0;
   localparam logic [2:0] M1_PAD = 3'h0;
   localparam logic [1:0] FRAMES_TO_ARM = 2'h2;
   // remote defect must show within this time; we update every frame
   localparam int unsigned RDI_REACT_US = 250;
   localparam int unsigned FRAME_US = 125;

   typedef logic [2:0][7:0] mstt_parity_t;

   // bytes outside the regenerator section overhead carry parity
   function automatic logic mstt_covered(input logic [3:0] row, input logic [8:0] col);
      return !((row < RSOH_ROWS) && (col < RSOH_COLS));
   endfunction

   // number of set bits in one octet
   function automatic logic [3:0] mstt_ones(input logic [7:0] b);
      logic [3:0] n;
      n = 4'h0;
      for (int i = 0; i < 8; i++) begin
         n = n + {3'h0, b[i]};
      end
      return n;
   endfunction

endpackage

/* hw/mstt_frame_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface mstt_frame_if;
   logic [7:0] data;
   logic valid;
   logic frame_start;
   logic [3:0] row;
   logic [8:0] col;
   logic [1:0] lane;
   mstt_pkg::mstt_parity_t parity_prev;

   // main logic feeds the octets and reads position and parity
   modport stream (output data, output valid, output frame_start,
                   input row, input col, input lane, input parity_prev);
   modport tracker (input data, input valid, input frame_start,
                    output row, output col, output lane, output parity_prev);
endinterface
`default_nettype wire

/* hw/mstt_bip_tracker.sv */
`timescale 1ns/10ps
`default_nettype none
module mstt_bip_tracker (
   input wire logic i_clock,
   input wire logic i_rst_n,
   mstt_frame_if.tracker f
);

   logic [3:0] row_ff;
   logic [8:0] col_ff;
   logic [1:0] lane_ff;
   mstt_pkg::mstt_parity_t acc_ff;
   mstt_pkg::mstt_parity_t prev_ff;
   logic [3:0] cur_row;
   logic [8:0] cur_col;
   logic [1:0] cur_lane;

   // ************************************************************
   // position of the octet on the port now
   // ************************************************************
   // frame start forces the first octet to row 0, column 0
   assign cur_row = f.frame_start ? 4'h0 : row_ff;
   assign cur_col = f.frame_start ? 9'h000 : col_ff;
   assign cur_lane = f.frame_start ? 2'h0 : lane_ff;
   assign f.row = cur_row;
   assign f.col = cur_col;
   assign f.lane = cur_lane;
   assign f.parity_prev = prev_ff;

   // advance position after each octet
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         row_ff <= 4'h0;
         col_ff <= 9'h000;
         lane_ff <= 2'h0;
      end else if (f.valid) begin
         lane_ff <= (cur_lane == mstt_pkg::LANE_LAST) ? 2'h0 : cur_lane + 2'h1;
         if (cur_col == mstt_pkg::COL_LAST) begin
            col_ff <= 9'h000;
            row_ff <= (cur_row == mstt_pkg::ROW_LAST) ? 4'h0 : cur_row + 4'h1;
         end else begin
            col_ff <= cur_col + 9'h001;
            row_ff <= cur_row;
         end
      end
   end

   // ************************************************************
   // interleaved even parity
   // ************************************************************
   // lane i takes every third octet, so parity bit i of lane covers interleave i
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         acc_ff <= '0;
         prev_ff <= '0;
      end else if (f.valid) begin
         if (f.frame_start) begin
            prev_ff <= acc_ff;
            acc_ff <= '0;
            if (mstt_pkg::mstt_covered(cur_row, cur_col)) begin
               acc_ff[cur_lane] <= f.data;
            end
         end else if (mstt_pkg::mstt_covered(cur_row, cur_col)) begin
            acc_ff[cur_lane] <= acc_ff[cur_lane] ^ f.data;
         end
      end
   end

endmodule
`default_nettype wire

/* hw/mstt.sv */
`timescale 1ns/10ps
`default_nettype none
module mstt (
   input wire logic i_clock,
   input wire logic i_nrst,
   input wire logic [7:0] i_adapted_data,
   input wire logic i_adapted_valid,
   input wire logic i_adapted_frame_start,
   input wire logic [4:0] i_remote_error_count_in,
   input wire logic i_remote_defect_flag_in,
   input wire logic [4:0] i_protection_k2,
   output logic [7:0] o_characteristic_data,
   output logic o_characteristic_valid,
   output logic o_characteristic_frame_start,
   input wire logic [7:0] i_characteristic_data,
   input wire logic i_characteristic_valid,
   input wire logic i_characteristic_frame_start,
   input wire logic i_aps_ring_mode,
   output logic [7:0] o_adapted_data,
   output logic o_adapted_valid,
   output logic o_adapted_frame_start,
   output logic [4:0] o_near_block_errors,
   output logic o_near_block_strobe,
   output logic [4:0] o_far_block_errors,
   output logic o_far_block_strobe,
   output logic o_remote_defect,
   output logic [4:0] o_protection_k2,
   output logic [15:0] o_aps_channel
);

   // ************************************************************
   // reset release
   // ************************************************************
   logic rst_meta_ff;
   logic rst_n_ff;

   // reset asserts at once but leaves through two flops
   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         rst_meta_ff <= 1'b0;
         rst_n_ff <= 1'b0;
      end else begin
         rst_meta_ff <= 1'b1;
         rst_n_ff <= rst_meta_ff;
      end
   end

   // ************************************************************
   // octet slot decode, shared by both directions
   // ************************************************************
   // one overhead octet at a fixed row and column
   function automatic logic mstt_at_slot(input logic [3:0] row,
                                         input logic [8:0] col,
                                         input logic [3:0] at_row,
                                         input logic [8:0] at_col);
      return (row == at_row) && (col == at_col);
   endfunction

   // the parity octets open their row, one for each interleave lane
   function automatic logic mstt_at_b2(input logic [3:0] row,
                                       input logic [8:0] col);
      return (row == mstt_pkg::B2_ROW) && (col < mstt_pkg::B2_COLS);
   endfunction

   // ************************************************************
   // source side: overhead insertion
   // ************************************************************
   mstt_frame_if src_if ();
   mstt_frame_if snk_if ();

   mstt_bip_tracker u_src_bip (
      .i_clock(i_clock),
      .i_rst_n(rst_n_ff),
      .f(src_if)
   );

   mstt_bip_tracker u_snk_bip (
      .i_clock(i_clock),
      .i_rst_n(rst_n_ff),
      .f(snk_if)
   );

   logic [7:0] nxt_src_byte;
   logic [4:0] rei_clamped;
   logic [2:0] rdi_code;
   logic src_b2_slot;
   logic src_k2_slot;
   logic src_m1_slot;

   // counts beyond the code range cannot be sent, so they saturate at the top
   assign rei_clamped = (i_remote_error_count_in > mstt_pkg::REI_MAX) ? mstt_pkg::REI_MAX
                        : i_remote_error_count_in;
   // the defect input is sampled at every K2 slot, so any change shows within one frame
   assign rdi_code = i_remote_defect_flag_in ? mstt_pkg::RDI_ON : mstt_pkg::RDI_OFF;

   // overhead positions of the outgoing frame
   assign src_b2_slot = mstt_at_b2(src_if.row, src_if.col);
   assign src_k2_slot = mstt_at_slot(src_if.row, src_if.col, mstt_pkg::B2_ROW, mstt_pkg::K2_COL);
   assign src_m1_slot = mstt_at_slot(src_if.row, src_if.col, mstt_pkg::M1_ROW, mstt_pkg::M1_COL);

   // pick the outgoing octet; everything else passes through untouched
   always_comb begin
      nxt_src_byte = i_adapted_data;
      if (src_b2_slot) begin
         nxt_src_byte = src_if.parity_prev[src_if.lane];
      end else if (src_k2_slot) begin
         nxt_src_byte = {i_protection_k2, rdi_code};
      end else if (src_m1_slot) begin
         nxt_src_byte = {mstt_pkg::M1_PAD, rei_clamped};
      end
   end

   // parity is taken over the octet as sent, inserted overhead included
   assign src_if.data = nxt_src_byte;
   assign src_if.valid = i_adapted_valid;
   assign src_if.frame_start = i_adapted_frame_start && i_adapted_valid;

   // register the outgoing stream
   always_ff @(posedge i_clock or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         o_characteristic_data <= 8'h00;
         o_characteristic_valid <= 1'b0;
         o_characteristic_frame_start <= 1'b0;
      end else begin
         o_characteristic_valid <= i_adapted_valid;
         o_characteristic_frame_start <= i_adapted_frame_start && i_adapted_valid;
         if (i_adapted_valid) begin
            o_characteristic_data <= nxt_src_byte;
         end
      end
   end

   // ************************************************************
   // sink side: parity check
   // ************************************************************
   logic snk_take;
   logic snk_fs;
   logic snk_b2_slot;
   logic snk_k1_slot;
   logic snk_k2_slot;
   logic snk_m1_slot;
   logic [3:0] snk_mismatch;
   logic [4:0] err_acc_ff;
   logic [1:0] frames_seen_ff;
   logic snk_armed;
   logic [7:0] k1_ff;
   logic [6:0] m1_code;

   // received stream feeds the sink position and parity tracker
   assign snk_take = i_characteristic_valid;
   assign snk_fs = i_characteristic_frame_start && i_characteristic_valid;
   assign snk_if.data = i_characteristic_data;
   assign snk_if.valid = snk_take;
   assign snk_if.frame_start = snk_fs;

   // overhead positions of the incoming frame
   assign snk_b2_slot = mstt_at_b2(snk_if.row, snk_if.col);
   assign snk_k1_slot = mstt_at_slot(snk_if.row, snk_if.col, mstt_pkg::B2_ROW, mstt_pkg::K1_COL);
   assign snk_k2_slot = mstt_at_slot(snk_if.row, snk_if.col, mstt_pkg::B2_ROW, mstt_pkg::K2_COL);
   assign snk_m1_slot = mstt_at_slot(snk_if.row, snk_if.col, mstt_pkg::M1_ROW, mstt_pkg::M1_COL);

   // each differing bit is one interleaved block in error
   assign snk_mismatch = mstt_pkg::mstt_ones(i_characteristic_data
                                             ^ snk_if.parity_prev[snk_if.lane]);

   // collect mismatches over the three B2 octets of a frame
   always_ff @(posedge i_clock or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         err_acc_ff <= 5'h00;
      end else if (snk_take) begin
         if (snk_fs) begin
            err_acc_ff <= 5'h00;
         end else if (snk_b2_slot) begin
            err_acc_ff <= err_acc_ff + {1'b0, snk_mismatch};
         end
      end
   end

   // reference parity is trusted only once two whole frames have passed
   assign snk_armed = (frames_seen_ff == mstt_pkg::FRAMES_TO_ARM);

   // the first frame after reset has no valid reference parity, so its count is never handed over
   always_ff @(posedge i_clock or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         frames_seen_ff <= 2'h0;
      end else if (snk_fs && !snk_armed) begin
         frames_seen_ff <= frames_seen_ff + 2'h1;
      end
   end

   // hand the count over once per frame, at the next frame start
   always_ff @(posedge i_clock or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         o_near_block_errors <= 5'h00;
         o_near_block_strobe <= 1'b0;
      end else begin
         o_near_block_strobe <= 1'b0;
         if (snk_fs && snk_armed) begin
            o_near_block_errors <= err_acc_ff;
            o_near_block_strobe <= 1'b1;
         end
      end
   end

   // ************************************************************
   // sink side: far-end count
   // ************************************************************
   // the top bit is dropped so old seven-bit senders decode alike
   assign m1_code = i_characteristic_data[6:0];

   always_ff @(posedge i_clock or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         o_far_block_errors <= 5'h00;
         o_far_block_strobe <= 1'b0;
      end else begin
         o_far_block_strobe <= 1'b0;
         if (snk_take && snk_m1_slot) begin
            o_far_block_strobe <= 1'b1;
            if (m1_code > mstt_pkg::REI_CODE_MAX) begin
               o_far_block_errors <= 5'h00;
            end else begin
               o_far_block_errors <= m1_code[4:0];
            end
         end
      end
   end

   // ************************************************************
   // sink side: K bytes
   // ************************************************************
   // K1 is held so the full APS word updates in one step at K2
   always_ff @(posedge i_clock or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         k1_ff <= 8'h00;
      end else if (snk_take && snk_k1_slot) begin
         k1_ff <= i_characteristic_data;
      end
   end

   // remote defect state and protection bits are refreshed once per frame
   always_ff @(posedge i_clock or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         o_remote_defect <= 1'b0;
         o_protection_k2 <= 5'h00;
      end else if (snk_take && snk_k2_slot) begin
         o_remote_defect <= (i_characteristic_data[2:0] == mstt_pkg::RDI_ON);
         o_protection_k2 <= i_characteristic_data[7:3];
      end
   end

   // linear mode drops the three defect bits; ring mode shows all sixteen
   always_ff @(posedge i_clock or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         o_aps_channel <= 16'h0000;
      end else if (snk_take && snk_k2_slot) begin
         if (i_aps_ring_mode) begin
            o_aps_channel <= {k1_ff, i_characteristic_data};
         end else begin
            o_aps_channel <= {k1_ff, i_characteristic_data[7:3], mstt_pkg::APS_PAD};
         end
      end
   end

   // ************************************************************
   // sink side: pass-through
   // ************************************************************
   // overhead stays in the octets; later adaptation ignores what it needs not
   always_ff @(posedge i_clock or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         o_adapted_data <= 8'h00;
         o_adapted_valid <= 1'b0;
         o_adapted_frame_start <= 1'b0;
      end else begin
         o_adapted_valid <= snk_take;
         o_adapted_frame_start <= snk_fs;
         if (snk_take) begin
            o_adapted_data <= i_characteristic_data;
         end
      end
   end

endmodule
`default_nettype wire

/* sim/mstt_props.sv */
`timescale 1ns/10ps
`default_nettype none
module mstt_props (
   input wire logic i_clock,
   input wire logic i_nrst,
   input wire logic i_adapted_valid,
   input wire logic i_adapted_frame_start,
   input wire logic [4:0] i_remote_error_count_in,
   input wire logic i_remote_defect_flag_in,
   input wire logic [4:0] i_protection_k2,
   input wire logic [7:0] o_characteristic_data,
   input wire logic [7:0] i_characteristic_data,
   input wire logic i_characteristic_valid,
   input wire logic i_characteristic_frame_start,
   input wire logic i_aps_ring_mode,
   input wire logic [4:0] o_near_block_errors,
   input wire logic o_near_block_strobe,
   input wire logic [4:0] o_far_block_errors,
   input wire logic o_far_block_strobe,
   input wire logic o_remote_defect,
   input wire logic [4:0] o_protection_k2,
   input wire logic [15:0] o_aps_channel
);
   // ********
   // octet position trackers
   // ********
   logic [11:0] sp_ff, qp_ff, si, qi;
   logic [2:0] k2lo;
   logic [4:0] k2hi, m1l;
   logic [6:0] m1c;
   logic sk, sm, qk, qm;
   // frame start restarts the index of the octet on the wire now
   assign si = i_characteristic_frame_start ? 12'h000 : sp_ff;
   assign qi = i_adapted_frame_start ? 12'h000 : qp_ff;
   assign k2lo = i_characteristic_data[2:0];
   assign k2hi = i_characteristic_data[7:3];
   assign m1c = i_characteristic_data[6:0];
   assign m1l = i_characteristic_data[4:0];
   assign sk = i_characteristic_valid && si == 12'h43e;
   assign sm = i_characteristic_valid && si == 12'h875;
   assign qk = i_adapted_valid && qi == 12'h43e;
   assign qm = i_adapted_valid && qi == 12'h875;
   // sink side index, valid octets only
   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         sp_ff <= 12'h000;
      end else if (i_characteristic_valid) begin
         sp_ff <= (si == 12'h97d) ? 12'h000 : si + 12'h001;
      end
   end
   // source side index
   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         qp_ff <= 12'h000;
      end else if (i_adapted_valid) begin
         qp_ff <= (qi == 12'h97d) ? 12'h000 : qi + 12'h001;
      end
   end
   default clocking cb @(posedge i_clock);
   endclocking
   default disable iff (!i_nrst);
   property p_m1_src;
      qm |=> o_characteristic_data ==
         {3'h0, ($past(i_remote_error_count_in) > 5'h18) ? 5'h18 : $past(i_remote_error_count_in)};
   endproperty
   a_m1_src: assert property (p_m1_src) else $error("m1 octet wrong");
   property p_k2_src;
      qk |=> o_characteristic_data == {$past(i_protection_k2), $past(i_remote_defect_flag_in) ? 3'h6 : 3'h0};
   endproperty
   a_k2_src: assert property (p_k2_src) else $error("k2 octet wrong");
   property p_rdi_snk;
      sk |=> o_remote_defect == ($past(k2lo) == 3'h6);
   endproperty
   a_rdi_snk: assert property (p_rdi_snk) else $error("defect decode wrong");
   property p_prot;
      sk |=> o_protection_k2 == $past(k2hi);
   endproperty
   a_prot: assert property (p_prot) else $error("protection bits wrong");
   property p_aps;
      sk |=> o_aps_channel[7:0] == {$past(k2hi), $past(i_aps_ring_mode) ? $past(k2lo) : 3'h0};
   endproperty
   a_aps: assert property (p_aps) else $error("aps channel wrong");
   property p_far;
      sm |=> o_far_block_strobe && o_far_block_errors == (($past(m1c) <= 7'h18) ? $past(m1l) : 5'h00);
   endproperty
   a_far: assert property (p_far) else $error("far count wrong");
   property p_near_fs;
      o_near_block_strobe |-> $past(i_characteristic_frame_start) && $past(i_characteristic_valid);
   endproperty
   a_near_fs: assert property (p_near_fs) else $error("near strobe off frame");
   property p_near_rng;
      o_near_block_strobe |-> o_near_block_errors <= 5'h18 ##1 !o_near_block_strobe;
   endproperty
   a_near_rng: assert property (p_near_rng) else $error("near count bad");
endmodule
bind mstt mstt_props u_props (.i_clock(i_clock), .i_nrst(i_nrst), .i_adapted_valid(i_adapted_valid),
   .i_adapted_frame_start(i_adapted_frame_start), .i_remote_error_count_in(i_remote_error_count_in),
   .i_remote_defect_flag_in(i_remote_defect_flag_in), .i_protection_k2(i_protection_k2),
   .o_characteristic_data(o_characteristic_data), .i_characteristic_data(i_characteristic_data),
   .i_characteristic_valid(i_characteristic_valid), .i_characteristic_frame_start(i_characteristic_frame_start),
   .i_aps_ring_mode(i_aps_ring_mode), .o_near_block_errors(o_near_block_errors),
   .o_near_block_strobe(o_near_block_strobe), .o_far_block_errors(o_far_block_errors),
   .o_far_block_strobe(o_far_block_strobe), .o_remote_defect(o_remote_defect),
   .o_protection_k2(o_protection_k2), .o_aps_channel(o_aps_channel));
`default_nettype wire

/* sim/mstt_feeder.sv */
`timescale 1ns/10ps
`default_nettype none
module mstt_feeder (
   input wire logic i_clock,
   input wire logic i_run,
   input wire logic i_slow,
   output logic [7:0] o_data,
   output logic o_valid,
   output logic o_frame_start
);
   // ********
   // adaptation side frame source
   // ********
   logic [11:0] idx = 12'h000;
   logic [7:0] fc = 8'h00;
   logic tick = 1'b0;
   initial begin
      o_data = 8'h00;
      o_valid = 1'b0;
      o_frame_start = 1'b0;
   end
   // content shifts every frame so stale parity never matches by luck
   always @(posedge i_clock) begin
      tick <= !tick;
      if (i_run && (!i_slow || tick)) begin
         o_valid <= 1'b1;
         o_frame_start <= idx == 12'h000;
         o_data <= idx[7:0] ^ fc;
         idx <= (idx == 12'h97d) ? 12'h000 : idx + 12'h001;
         fc <= (idx == 12'h97d) ? fc + 8'h01 : fc;
      end else begin
         o_valid <= 1'b0;
         o_frame_start <= 1'b0;
         o_data <= ~o_data;
      end
   end
endmodule
`default_nettype wire

/* sim/mstt_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module mstt_tb;
   logic i_clock = 1'b0;
   logic i_nrst = 1'b0;
   logic run = 1'b0;
   logic slow = 1'b0;
   logic ring = 1'b0;
   logic rdi = 1'b0;
   logic [4:0] rei = 5'h00;
   logic [4:0] prot = 5'h00;
   logic [7:0] cd = 8'h00;
   logic cv = 1'b0;
   logic cf = 1'b0;
   logic [7:0] fd, od, x, k2s, m1s, m1v;
   logic fv, ff, ov, of, ns, fs, rd;
   logic m1f = 1'b0;
   logic [7:0] ad;
   logic [7:0] pcd = 8'h00;
   logic av, af;
   logic pcv = 1'b0;
   logic pcf = 1'b0;
   logic [4:0] ne, fe, pk;
   logic [15:0] aps;
   mstt_pkg::mstt_parity_t par = '0;
   mstt_pkg::mstt_parity_t prv = '0;
   int fails = 0;
   int checked = 0;
   int cur = 0;
   int pos = 0;
   int frm = 0;
   int bad = -1;
   mstt_feeder u_feed (.i_clock(i_clock), .i_run(run), .i_slow(slow), .o_data(fd), .o_valid(fv),
      .o_frame_start(ff));
   mstt u_dut (.i_clock(i_clock), .i_nrst(i_nrst), .i_adapted_data(fd), .i_adapted_valid(fv),
      .i_adapted_frame_start(ff), .i_remote_error_count_in(rei), .i_remote_defect_flag_in(rdi),
      .i_protection_k2(prot), .o_characteristic_data(od), .o_characteristic_valid(ov),
      .o_characteristic_frame_start(of), .i_characteristic_data(cd), .i_characteristic_valid(cv),
      .i_characteristic_frame_start(cf), .i_aps_ring_mode(ring), .o_adapted_data(ad), .o_adapted_valid(av),
      .o_adapted_frame_start(af), .o_near_block_errors(ne), .o_near_block_strobe(ns), .o_far_block_errors(fe),
      .o_far_block_strobe(fs), .o_remote_defect(rd), .o_protection_k2(pk), .o_aps_channel(aps));
   // ********
   // shared helpers
   // ********
   always #20 i_clock = ~i_clock;
   task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // loop source output into the sink, with planned damage
   always @(posedge i_clock) begin
      x = od;
      if (ov) begin
         cur = of ? 0 : pos;
         if (of) begin
            frm++;
            prv = par;
            par = '0;
         end
         pos = cur + 1;
         if (frm > 1 && cur >= 1080 && cur <= 1082) chk("b2 sent", od, prv[cur - 1080]);
         if (cur / 270 > 2 || cur % 270 > 8) par[(cur % 270) % 3] ^= od;
         if (cur == 1086) k2s = od;
         if (cur == 2165) m1s = od;
         if (frm == bad && cur == 4) x = od ^ 8'hff; // overhead hit must not count
         if (frm == bad && cur == 501) x = od ^ 8'h01;
         if (frm == bad && cur == 1081) x = od ^ 8'h30;
         if (frm == bad && cur == 2000) x = od ^ 8'h83;
         if (m1f && cur == 2165) x = m1v;
      end
      // the sink hands every received octet on, one cycle later and unchanged
      if (av === 1'b1 || pcv === 1'b1) begin
         chk("pass valid", {7'h00, av}, {7'h00, pcv});
         chk("pass start", {7'h00, af}, {7'h00, pcf});
         chk("pass data", ad, pcd);
      end
      pcd <= cd;
      pcv <= cv;
      pcf <= cf;
      cd <= x;
      cv <= ov;
      cf <= of;
   end
   // bounded wait for a near (n=1) or far strobe
   task automatic wstb(input bit n, output logic [4:0] v);
      int i;
      i = 0;
      do begin
         @(posedge i_clock);
         #1;
         i++;
      end while ((n ? ns : fs) !== 1'b1 && i < 6000);
      if (i >= 6000) fails++;
      v = n ? ne : fe;
   endtask
   task automatic wfr(input int n);
      int t;
      t = frm + n;
      while (frm < t) begin
         @(posedge i_clock);
         #1;
      end
   endtask
   // ********
   // scenarios
   // ********
   task automatic t_rei;
      logic [4:0] g;
      logic [4:0] tv [3] = '{5'h0d, 5'h18, 5'h1f};
      for (int k = 0; k < 3; k++) begin
         @(posedge i_clock);
         rei <= tv[k];
         wstb(0, g);
         wstb(0, g);
         chk("far count", 8'(g), k ? 8'h18 : 8'h0d);
         chk("m1 sent", m1s, k ? 8'h18 : 8'h0d);
      end
      $display("test rei done");
   endtask
   task automatic t_m1;
      logic [4:0] g;
      logic [7:0] cv8 [5] = '{8'h98, 8'h19, 8'h7f, 8'hff, 8'h8c};
      logic [7:0] ev [5] = '{8'h18, 8'h00, 8'h00, 8'h00, 8'h0c};
      for (int k = 0; k < 5; k++) begin
         m1v = cv8[k];
         m1f = 1'b1;
         wstb(0, g);
         wstb(0, g);
         chk("m1 decode", 8'(g), ev[k]);
      end
      m1f = 1'b0;
      $display("test m1 decode done");
   endtask
   task automatic t_near;
      logic [4:0] g;
      // one spare frame so the m1 octet altered last leaves the reference clean
      bad = frm + 2;
      wfr(3);
      wstb(1, g);
      chk("near b2 hit", 8'(g), 8'h02);
      wstb(1, g);
      chk("near payload", 8'(g), 8'h06);
      wstb(1, g);
      chk("near clean", 8'(g), 8'h00);
      $display("test near done");
   endtask
   task automatic t_rdi;
      @(posedge i_clock);
      rdi <= 1'b1;
      wfr(2);
      chk("k2 set", 8'(k2s[2:0]), 8'h06);
      chk("defect seen", 8'(rd), 8'h01);
      @(posedge i_clock);
      rdi <= 1'b0;
      wfr(2);
      chk("k2 clear", 8'(k2s[2:0]), 8'h00);
      chk("defect gone", 8'(rd), 8'h00);
      $display("test defect done");
   endtask
   task automatic t_aps;
      @(posedge i_clock);
      prot <= 5'h15;
      rdi <= 1'b1;
      slow <= 1'b1;
      wfr(2);
      chk("aps linear", aps[7:0], 8'ha8);
      chk("prot k2", 8'(pk), 8'h15);
      @(posedge i_clock);
      slow <= 1'b0;
      ring <= 1'b1;
      wfr(2);
      chk("aps ring", aps[7:0], 8'hae);
      chk("k2 sent", k2s, 8'hae);
      $display("test aps done");
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // watchdog sized above the roughly 78k cycles of traffic
   initial begin
      repeat (100000) @(posedge i_clock);
      fails++;
      report_and_stop;
   end
   initial begin
      repeat (20) @(posedge i_clock);
      i_nrst <= 1'b1;
      repeat (5) @(posedge i_clock);
      run <= 1'b1;
      wfr(3);
      t_rei;
      t_m1;
      t_near;
      t_rdi;
      t_aps;
      report_and_stop;
   end
endmodule
`default_nettype wire
